// [design/aar_pkg.sv]
// Constants, record layout and state types of the alert reporter.
// Assumes a single 125 MHz clock and byte-wide message transmit.
package aar_pkg;

	// ----------------------------------------
	// Ports and queues
	// ----------------------------------------
	localparam int AAR_PORTS = 2;
	localparam int AAR_PW = 1;
	localparam int AAR_QDEPTH = 4;
	localparam int AAR_QAW = 2;
	localparam int AAR_QCW = 3;

	// ----------------------------------------
	// Message layout
	// ----------------------------------------
	localparam logic [7:0] AAR_CODE_ALERT = 8'h04;
	localparam logic [7:0] AAR_RSVD_BYTE = 8'h00;
	localparam int AAR_HDR_BYTES = 11;
	localparam int AAR_MAX_DATA = 21;
	localparam int AAR_DLW = 5;
	localparam int AAR_IDXW = 6;
	localparam int AAR_MA_TYPE_BYTE = 16;
	localparam int AAR_MA_SUB_BYTE = 17;
	localparam int AAR_MA_INFO_BYTE = 18;
	localparam int AAR_PATH_BYTES = 4;
	localparam int AAR_EXT_BIT = 7;

	// ----------------------------------------
	// Alert codes and reply codes
	// ----------------------------------------
	localparam logic [7:0] AAR_TYPE_ERP_LO = 8'h10;
	localparam logic [7:0] AAR_TYPE_ERP_HI = 8'h19;
	localparam logic [7:0] AAR_NOP_TYPE = 8'h01;
	localparam logic [7:0] AAR_NOP_SUB = 8'h01;
	localparam logic [7:0] AAR_NOP_INFO = 8'h00;
	localparam logic [7:0] AAR_RC_OK = 8'h00;
	localparam logic [7:0] AAR_RC_INVALID = 8'hff;

	// ----------------------------------------
	// Tag pools
	// ----------------------------------------
	localparam int AAR_CLS_W = 3;
	localparam int AAR_CLASSES = 6;
	localparam logic [2:0] AAR_CLS_RESP = 3'h5;
	localparam int AAR_SLOTS = 4;
	localparam int AAR_SLOT_W = 2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int AAR_CLK_HZ = 125000000;
	localparam int AAR_RETX_MS = 500;
	localparam int AAR_RETX_CYCLES = AAR_CLK_HZ / 1000 * AAR_RETX_MS;
	localparam int AAR_TMR_W = 26;

	typedef struct packed {
		logic [7:0] typ;
		logic [7:0] sub;
		logic [7:0] info;
		logic [7:0] ctrl;
		logic [15:0] chan;
		logic [8*AAR_MAX_DATA-1:0] data;
		logic [AAR_DLW-1:0] dlen;
	} aar_rec_type;

	typedef enum logic [1:0] {
		AAR_ARB_IDLE = 2'b00,
		AAR_ARB_SEND = 2'b01
	} aar_arb_type;

	typedef enum logic [1:0] {
		AAR_FR_IDLE = 2'b00,
		AAR_FR_RUN = 2'b01
	} aar_fr_type;

endpackage

// [design/aar_frame_if.sv]
// Hand-off between the alert scheduler and the message framer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface aar_frame_if;
	import aar_pkg::*;
	logic start;
	logic abort;
	logic [7:0] port;
	logic [15:0] tag;
	aar_rec_type rec;
	logic busy;
	logic done;
	modport src (output start, output abort, output port, output tag, output rec, input busy, input done);
	modport snk (input start, input abort, input port, input tag, input rec, output busy, output done);
endinterface

// [design/aar_framer.sv]
// Serialises one alert message into bytes on the transmit port.
// Assumes the record fields stay stable from start until done.
`timescale 1ns/100ps
module aar_framer import aar_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	aar_frame_if.snk f,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last
);

	aar_fr_type state_r;
	logic [AAR_IDXW-1:0] idx_r;
	logic [AAR_IDXW-1:0] total;
	logic done_r;

	// Byte at a position of the message
	function automatic logic [7:0] msg_byte(input logic [AAR_IDXW-1:0] i, input logic [7:0] p,
		input logic [15:0] t, input aar_rec_type r);
		int k;
		k = int'(i) - AAR_HDR_BYTES;
		case (i)
			6'h00: msg_byte = AAR_CODE_ALERT;
			6'h01: msg_byte = p;
			6'h02: msg_byte = t[15:8];
			6'h03: msg_byte = t[7:0];
			6'h04: msg_byte = r.typ;
			6'h05: msg_byte = r.sub;
			6'h06: msg_byte = r.info;
			6'h07: msg_byte = AAR_RSVD_BYTE;
			6'h08: msg_byte = r.ctrl;
			6'h09: msg_byte = r.chan[15:8];
			6'h0a: msg_byte = r.chan[7:0];
			default: msg_byte = r.data[8*k +: 8];
		endcase
	endfunction

	assign total = AAR_IDXW'(AAR_HDR_BYTES) + {1'b0, f.rec.dlen};
	assign f.busy = (state_r == AAR_FR_RUN);
	assign f.done = done_r;

	// Byte sequencer
	always_ff @(posedge clock) begin
		if (rst || f.abort) begin
			state_r <= AAR_FR_IDLE;
			idx_r <= 6'h00;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				AAR_FR_IDLE: begin
					if (f.start) begin
						tx_data <= msg_byte(6'h00, f.port, f.tag, f.rec);
						tx_valid <= 1'b1;
						tx_last <= 1'b0;
						idx_r <= 6'h01;
						state_r <= AAR_FR_RUN;
					end
				end
				AAR_FR_RUN: begin
					if (tx_ready) begin
						if (tx_last) begin
							tx_valid <= 1'b0;
							tx_last <= 1'b0;
							done_r <= 1'b1;
							state_r <= AAR_FR_IDLE;
						end else begin
							tx_data <= msg_byte(idx_r, f.port, f.tag, f.rec);
							tx_last <= (idx_r == total - 6'h01);
							idx_r <= idx_r + 6'h01;
						end
					end
				end
				default: state_r <= AAR_FR_IDLE;
			endcase
		end
	end

endmodule // aar_framer

// [design/aar_alert_reporter.sv]
// Alert reporter: queues, sends, retransmits and retires alerts per port,
// and hands out transport tags from the tag pools.
// Assumes all inputs are synchronous to clock and single-cycle strobes.
`timescale 1ns/100ps
module aar_alert_reporter import aar_pkg::*; #(
	parameter int RETX_CYCLES = AAR_RETX_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic alert_valid,
	input wire logic [AAR_PW-1:0] alert_port,
	input wire logic [AAR_PW-1:0] alert_exit_port,
	input wire logic alert_port_down,
	input wire logic [7:0] alert_type,
	input wire logic [7:0] alert_subtype,
	input wire logic [7:0] alert_info,
	input wire logic [7:0] alert_ctrl,
	input wire logic [15:0] alert_chan,
	input wire logic [8*AAR_MAX_DATA-1:0] alert_data,
	input wire logic [AAR_DLW-1:0] alert_dlen,
	input wire logic cfg_valid,
	input wire logic [AAR_PW-1:0] cfg_port,
	input wire logic [15:0] cfg_tag,
	input wire logic [31:0] cfg_path,
	input wire logic reply_valid,
	input wire logic [AAR_PW-1:0] reply_port,
	input wire logic [15:0] reply_tag,
	input wire logic [7:0] reply_code,
	input wire logic total_reset,
	input wire logic absolute_reset,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	output logic [AAR_PW-1:0] tx_port_r,
	output logic [31:0] tx_path_r,
	output logic [2:0] tx_path_len_r,
	output logic [AAR_PORTS-1:0] pending_r,
	output logic [AAR_PORTS-1:0] queue_full_r,
	output logic alert_overflow_r,
	output logic alert_discard_r,
	output logic ack_r,
	output logic [AAR_PW-1:0] ack_port_r,
	output logic ack_invalid_r,
	output logic reply_discard_r,
	input wire logic pool_separate,
	input wire logic tag_req_valid,
	input wire logic [AAR_CLS_W-1:0] tag_req_class,
	input wire logic tag_rel_valid,
	input wire logic [AAR_CLS_W-1:0] tag_rel_class,
	input wire logic [15:0] tag_rel_tag,
	output logic tag_grant_r,
	output logic tag_fail_r,
	output logic [15:0] tag_grant_tag_r,
	output logic tag_rel_bad_r
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	aar_frame_if fif ();
	aar_rec_type q_mem [AAR_PORTS][AAR_QDEPTH];
	aar_rec_type new_rec;
	aar_rec_type fr_rec_r;
	logic [AAR_QAW-1:0] q_wr_r [AAR_PORTS];
	logic [AAR_QAW-1:0] q_rd_r [AAR_PORTS];
	logic [AAR_QCW-1:0] q_cnt_r [AAR_PORTS];
	logic [AAR_TMR_W-1:0] tmr_r [AAR_PORTS];
	logic [15:0] tag_r [AAR_PORTS];
	logic [31:0] path_r [AAR_PORTS];
	logic [AAR_PORTS-1:0] tag_ok_r;
	logic [AAR_PORTS-1:0] enq;
	logic [AAR_PORTS-1:0] ack;
	logic [AAR_PORTS-1:0] expired;
	logic [AAR_PORTS-1:0] want;
	logic [AAR_PORTS-1:0] start_p;
	aar_arb_type state_r;
	logic [AAR_PW-1:0] sel_r;
	logic [AAR_PW-1:0] pick;
	logic [15:0] fr_tag_r;
	logic start_r;
	logic abort_r;
	logic fsr;
	logic drop_erp;
	logic [AAR_SLOTS-1:0] used_r [AAR_CLASSES];
	logic [AAR_CLS_W-1:0] req_pool;
	logic [AAR_CLS_W-1:0] rel_pool;
	logic [AAR_SLOT_W-1:0] free_slot;
	logic free_any;
	logic rel_ok;

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Link recovery-exit alert types
	function automatic logic is_erp(input logic [7:0] t);
		is_erp = (t >= AAR_TYPE_ERP_LO) && (t <= AAR_TYPE_ERP_HI);
	endfunction

	// Number of significant path bytes up to a clear extend flag
	function automatic logic [2:0] path_len(input logic [31:0] p);
		int i;
		logic go;
		path_len = 3'h1;
		go = 1'b1;
		for (i = 0; i < AAR_PATH_BYTES - 1; i++) begin
			go = go && p[31 - 8*i - (7 - AAR_EXT_BIT)];
			if (go) begin
				path_len = path_len + 3'h1;
			end
		end
	endfunction

	// Path with pad bytes cleared
	function automatic logic [31:0] path_trim(input logic [31:0] p);
		int i;
		path_trim = p;
		for (i = 0; i < AAR_PATH_BYTES; i++) begin
			if (i >= int'(path_len(p))) begin
				path_trim[31 - 8*i -: 8] = 8'h00;
			end
		end
	endfunction

	// Pool serving a message class
	function automatic logic [AAR_CLS_W-1:0] pool_of(input logic [AAR_CLS_W-1:0] c, input logic sep);
		if (!sep) begin
			pool_of = AAR_CLS_RESP;
		end else if (c >= AAR_CLS_W'(AAR_CLASSES)) begin
			pool_of = AAR_CLS_RESP;
		end else begin
			pool_of = c;
		end
	endfunction

	// Round-robin choice starting after the last served port
	function automatic logic [AAR_PW-1:0] rr_pick(input logic [AAR_PORTS-1:0] w, input logic [AAR_PW-1:0] last);
		int i;
		logic [AAR_PW-1:0] idx;
		rr_pick = last;
		for (i = AAR_PORTS; i >= 1; i--) begin
			idx = AAR_PW'((int'(last) + i) % AAR_PORTS);
			if (w[idx]) begin
				rr_pick = idx;
			end
		end
	endfunction

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	assign fsr = total_reset | absolute_reset;
	assign drop_erp = is_erp(alert_type) && !alert_port_down && (alert_exit_port == alert_port);
	assign pick = rr_pick(want, sel_r);

	// Record built from an incoming alert
	always_comb begin
		new_rec.typ = alert_port_down ? AAR_NOP_TYPE : alert_type;
		new_rec.sub = alert_port_down ? AAR_NOP_SUB : alert_subtype;
		new_rec.info = alert_port_down ? AAR_NOP_INFO : alert_info;
		new_rec.ctrl = alert_ctrl;
		new_rec.chan = alert_chan;
		new_rec.data = alert_data;
		new_rec.dlen = (alert_dlen > AAR_DLW'(AAR_MAX_DATA)) ? AAR_DLW'(AAR_MAX_DATA) : alert_dlen;
	end

	// Per-port strobes
	always_comb begin
		for (int p = 0; p < AAR_PORTS; p++) begin
			enq[p] = alert_valid && !fsr && !drop_erp && (alert_port == AAR_PW'(p))
				&& (q_cnt_r[p] != AAR_QCW'(AAR_QDEPTH));
			ack[p] = reply_valid && !fsr && (reply_port == AAR_PW'(p)) && pending_r[p]
				&& (reply_tag == tag_r[p]);
			expired[p] = (tmr_r[p] == AAR_TMR_W'(RETX_CYCLES - 1));
			want[p] = (q_cnt_r[p] != 3'h0) && tag_ok_r[p] && (!pending_r[p] || expired[p]) && !ack[p]
				&& !fsr;
			start_p[p] = (state_r == AAR_ARB_IDLE) && want[p] && (pick == AAR_PW'(p));
		end
	end

	// ----------------------------------------
	// Alert queues
	// ----------------------------------------

	// Queue storage
	always_ff @(posedge clock) begin
		for (int p = 0; p < AAR_PORTS; p++) begin
			if (enq[p]) begin
				q_mem[p][q_wr_r[p]] <= new_rec;
			end
		end
	end

	// Queue pointers and fill
	always_ff @(posedge clock) begin
		for (int p = 0; p < AAR_PORTS; p++) begin
			if (rst || fsr) begin
				q_wr_r[p] <= 2'h0;
				q_rd_r[p] <= 2'h0;
				q_cnt_r[p] <= 3'h0;
				queue_full_r[p] <= 1'b0;
			end else begin
				q_wr_r[p] <= q_wr_r[p] + AAR_QAW'(enq[p]);
				q_rd_r[p] <= q_rd_r[p] + AAR_QAW'(ack[p]);
				q_cnt_r[p] <= q_cnt_r[p] + AAR_QCW'(enq[p]) - AAR_QCW'(ack[p]);
				queue_full_r[p] <= (q_cnt_r[p] + AAR_QCW'(enq[p]) - AAR_QCW'(ack[p])) == AAR_QCW'(AAR_QDEPTH);
			end
		end
	end

	// Dropped alert strobes
	always_ff @(posedge clock) begin
		if (rst) begin
			alert_overflow_r <= 1'b0;
			alert_discard_r <= 1'b0;
		end else begin
			alert_overflow_r <= alert_valid && !fsr && !drop_erp && !enq[alert_port];
			alert_discard_r <= alert_valid && !fsr && drop_erp;
		end
	end

	// ----------------------------------------
	// Pending state and resend timers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		for (int p = 0; p < AAR_PORTS; p++) begin
			if (rst || fsr) begin
				pending_r[p] <= 1'b0;
				tmr_r[p] <= '0;
			end else if (ack[p]) begin
				pending_r[p] <= 1'b0;
				tmr_r[p] <= '0;
			end else if (start_p[p]) begin
				pending_r[p] <= 1'b1;
				tmr_r[p] <= '0;
			end else if (pending_r[p] && !expired[p]) begin
				tmr_r[p] <= tmr_r[p] + AAR_TMR_W'(1);
			end
		end
	end

	// Reply bookkeeping
	always_ff @(posedge clock) begin
		if (rst) begin
			ack_r <= 1'b0;
			ack_port_r <= '0;
			ack_invalid_r <= 1'b0;
			reply_discard_r <= 1'b0;
		end else begin
			ack_r <= |ack;
			reply_discard_r <= reply_valid && !fsr && !(|ack);
			if (|ack) begin
				ack_port_r <= reply_port;
				ack_invalid_r <= (reply_code == AAR_RC_INVALID);
			end
		end
	end

	// ----------------------------------------
	// Port configuration
	// ----------------------------------------
	always_ff @(posedge clock) begin
		for (int p = 0; p < AAR_PORTS; p++) begin
			if (rst || fsr) begin
				tag_ok_r[p] <= 1'b0;
				tag_r[p] <= 16'h0000;
				path_r[p] <= 32'h00000000;
			end else if (cfg_valid && (cfg_port == AAR_PW'(p))) begin
				tag_ok_r[p] <= 1'b1;
				tag_r[p] <= cfg_tag;
				path_r[p] <= cfg_path;
			end
		end
	end

	// ----------------------------------------
	// Send scheduler
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= AAR_ARB_IDLE;
			sel_r <= '0;
			start_r <= 1'b0;
			abort_r <= 1'b0;
			fr_tag_r <= 16'h0000;
			fr_rec_r <= '0;
			tx_port_r <= '0;
			tx_path_r <= 32'h00000000;
			tx_path_len_r <= 3'h0;
		end else begin
			start_r <= 1'b0;
			abort_r <= fsr;
			if (fsr) begin
				state_r <= AAR_ARB_IDLE;
			end else begin
				case (state_r)
					AAR_ARB_IDLE: begin
						if (|want) begin
							sel_r <= pick;
							fr_rec_r <= q_mem[pick][q_rd_r[pick]];
							fr_tag_r <= tag_r[pick];
							tx_port_r <= pick;
							tx_path_r <= path_trim(path_r[pick]);
							tx_path_len_r <= path_len(path_r[pick]);
							start_r <= 1'b1;
							state_r <= AAR_ARB_SEND;
						end
					end
					AAR_ARB_SEND: begin
						if (fif.done) begin
							state_r <= AAR_ARB_IDLE;
						end
					end
					default: state_r <= AAR_ARB_IDLE;
				endcase
			end
		end
	end

	assign fif.start = start_r;
	assign fif.abort = abort_r;
	assign fif.port = 8'(sel_r);
	assign fif.tag = fr_tag_r;
	assign fif.rec = fr_rec_r;

	aar_framer u_framer (
		.clock(clock),
		.rst(rst),
		.f(fif.snk),
		.tx_ready(tx_ready),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_last(tx_last)
	);

	// ----------------------------------------
	// Transport tag pools
	// ----------------------------------------
	assign req_pool = pool_of(tag_req_class, pool_separate);
	assign rel_pool = pool_of(tag_rel_class, pool_separate);
	assign rel_ok = (tag_rel_tag[15:AAR_SLOT_W] == 14'(rel_pool)) && used_r[rel_pool][tag_rel_tag[AAR_SLOT_W-1:0]];

	// Lowest free slot of the requested pool
	always_comb begin
		free_any = 1'b0;
		free_slot = '0;
		for (int s = AAR_SLOTS - 1; s >= 0; s--) begin
			if (!used_r[req_pool][s]) begin
				free_any = 1'b1;
				free_slot = AAR_SLOT_W'(s);
			end
		end
	end

	// Allocation and release; tags stand apart from protocol-layer tags
	always_ff @(posedge clock) begin
		if (rst || fsr) begin
			for (int c = 0; c < AAR_CLASSES; c++) begin
				used_r[c] <= '0;
			end
			tag_grant_r <= 1'b0;
			tag_fail_r <= 1'b0;
			tag_grant_tag_r <= 16'h0000;
			tag_rel_bad_r <= 1'b0;
		end else begin
			tag_grant_r <= tag_req_valid && free_any;
			tag_fail_r <= tag_req_valid && !free_any;
			tag_rel_bad_r <= tag_rel_valid && !rel_ok;
			if (tag_rel_valid && rel_ok) begin
				used_r[rel_pool][tag_rel_tag[AAR_SLOT_W-1:0]] <= 1'b0;
			end
			if (tag_req_valid && free_any) begin
				used_r[req_pool][free_slot] <= 1'b1;
				tag_grant_tag_r <= {14'(req_pool), free_slot};
			end
		end
	end

endmodule // aar_alert_reporter

// [tb/aar_checker.sv]
// Port checker of the alert reporter, bound into its top module.
// Assumes one clock domain and synchronous active-high rst.
`timescale 1ns/100ps
module aar_checker import aar_pkg::*; #(
	parameter int RETX_CYCLES = AAR_RETX_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic alert_valid,
	input wire logic [AAR_PW-1:0] alert_port,
	input wire logic [AAR_PW-1:0] alert_exit_port,
	input wire logic alert_port_down,
	input wire logic [7:0] alert_type,
	input wire logic reply_valid,
	input wire logic [AAR_PW-1:0] reply_port,
	input wire logic total_reset,
	input wire logic absolute_reset,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic [AAR_PORTS-1:0] pending_r,
	input wire logic [AAR_PORTS-1:0] queue_full_r,
	input wire logic alert_overflow_r,
	input wire logic alert_discard_r,
	input wire logic ack_r,
	input wire logic [AAR_PW-1:0] ack_port_r,
	input wire logic reply_discard_r
);
	// Recovery exit leaving through the failing port
	wire erp_same = alert_type >= AAR_TYPE_ERP_LO && alert_type <= AAR_TYPE_ERP_HI &&
		alert_exit_port == alert_port && !alert_port_down;
	wire any_rst = total_reset || absolute_reset;
	int idle_r;

	// Cycles with an alert pending and the link silent
	always_ff @(posedge clock) begin
		if (rst || tx_valid || pending_r == '0) idle_r <= 0;
		else idle_r <= idle_r + 1;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	AST_TX_HOLD: assert property (tx_valid && !tx_ready && !any_rst && !$past(any_rst) |=>
		tx_valid && $stable(tx_data)) else $error("byte changed before taken");
	AST_FIRST_CODE: assert property ($rose(tx_valid) |-> tx_data == AAR_CODE_ALERT)
		else $error("message does not start with alert code");
	AST_ERP_DROP: assert property (alert_valid && erp_same && !any_rst |=> alert_discard_r)
		else $error("same-port recovery alert not dropped");
	AST_OTHER_KEPT: assert property (alert_valid && !erp_same && !any_rst |=> !alert_discard_r)
		else $error("reportable alert dropped");
	AST_FULL_OVF: assert property (alert_valid && !erp_same && !any_rst && queue_full_r[alert_port] |=>
		alert_overflow_r) else $error("alert on full queue not refused");
	AST_NO_PEND: assert property (reply_valid && !pending_r[reply_port] && !any_rst |=>
		reply_discard_r && !ack_r) else $error("reply without pending not discarded");
	AST_ACK_CLEAR: assert property (ack_r |-> !pending_r[ack_port_r] && $past(reply_valid))
		else $error("ack without reply or pending left set");
	AST_RESET_CLEAR: assert property (any_rst |-> ##3 pending_r == '0 && !tx_valid)
		else $error("node reset left alert pending");
	AST_RESEND_DUE: assert property (idle_r <= RETX_CYCLES + 8)
		else $error("pending alert not resent in time");

	COV_ACK: cover property (ack_r);
	COV_DROP: cover property (alert_discard_r);
	COV_OVF: cover property (alert_overflow_r);
endmodule // aar_checker

bind aar_alert_reporter aar_checker #(.RETX_CYCLES(RETX_CYCLES)) aar_checker_inst (.*);

// [tb/aar_master_model.sv]
// Master node stand-in: takes alert bytes, answers with replies.
// Assumes bytes of one message follow back to back.
`timescale 1ns/100ps
module aar_master_model (
	input wire logic clock,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic stall,
	input wire logic answer,
	input wire logic twice,
	input wire logic [15:0] tag_xor,
	output logic tx_ready,
	output logic reply_valid,
	output logic reply_port,
	output logic [7:0] reply_code,
	output logic [15:0] reply_tag,
	output logic [7:0] msg [32],
	output int msg_len,
	output int msg_cnt
);
	int n = 0;
	int due = 0;
	int gap = 0;
	logic slow = 0;

	initial begin
		{tx_ready, reply_valid, reply_port, reply_code, reply_tag} = '0;
		{msg_len, msg_cnt} = '0;
	end

	// Collect bytes, one message per last byte
	always @(posedge clock) begin
		if (!tx_valid) n = 0;
		else if (tx_ready) begin
			msg[n] = tx_data;
			n++;
			if (tx_last) begin
				{msg_len, msg_cnt, n, gap} = {n, msg_cnt + 1, 32'sd0, 32'sd3};
				due = answer ? (twice ? 2 : 1) : 0;
			end
		end
	end

	// Ready and replies change off the sampling edge
	always @(negedge clock) begin
		slow <= ~slow;
		tx_ready <= !stall || slow;
		if (due > 0 && gap == 0) begin
			reply_valid <= 1'h1;
			reply_port <= msg[1][0];
			reply_tag <= {msg[2], msg[3]} ^ tag_xor;
			reply_code <= twice ? 8'hff : 8'h00;
			{due, gap} = {due - 1, 32'sd2};
		end else begin
			reply_valid <= 1'h0;
			reply_tag <= ~reply_tag;
			if (gap > 0) gap--;
		end
	end
endmodule // aar_master_model

// [tb/aar_alert_reporter_test.sv]
// Testbench of the alert reporter against the master stand-in.
// Assumes a short resend count so copies come quickly.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module aar_alert_reporter_test import aar_pkg::*; ;
	localparam int RETX = 200;
	typedef struct {logic p; logic x; logic dn; logic [7:0] ty; int dl; logic sent;} aar_row_type;
	aar_row_type rows [6] = '{'{0, 1, 0, 8'h02, 21, 1}, '{1, 0, 0, 8'h03, 0, 1}, '{0, 1, 0, 8'h10, 5, 1},
		'{1, 1, 0, 8'h19, 3, 0}, '{0, 0, 1, 8'h10, 2, 1}, '{1, 0, 0, 8'h04, 1, 1}};
	logic [15:0] tagv [2] = '{16'h1234, 16'h0abc};
	logic [31:0] pth [2] = '{32'h8102aabb, 32'h83848506};
	logic [34:0] epth [2] = '{{32'h81020000, 3'h2}, {32'h83848506, 3'h4}};
	logic clock = 0, rst = 1, alert_valid = 0, alert_port = 0, alert_exit_port = 0, alert_port_down = 0;
	logic [7:0] alert_type = 0, alert_subtype = 0, alert_info = 0, alert_ctrl = 0, reply_code, tx_data, msg [32];
	logic [15:0] alert_chan = 0, cfg_tag = 0, tag_rel_tag = 0, tag_xor = 0, reply_tag, tag_grant_tag_r;
	logic [8*AAR_MAX_DATA-1:0] alert_data;
	logic [AAR_DLW-1:0] alert_dlen = 0;
	logic [31:0] cfg_path = 0, tx_path_r;
	logic [2:0] tag_req_class = 0, tag_rel_class = 0, tx_path_len_r;
	logic cfg_valid = 0, cfg_port = 0, total_reset = 0, absolute_reset = 0, pool_separate = 0, tag_req_valid = 0;
	logic tag_rel_valid = 0, stall = 0, answer = 1, twice = 0, tx_ready, reply_valid, reply_port;
	logic tx_valid, tx_last, tx_port_r, alert_overflow_r, alert_discard_r, ack_r, ack_port_r, ack_invalid_r;
	logic reply_discard_r, tag_grant_r, tag_fail_r, tag_rel_bad_r;
	logic [1:0] pending_r, queue_full_r;
	int msg_len, msg_cnt, err_count = 0, samples_checked = 0, ack_n = 0, disc_n = 0, ovf_n = 0, cyc = 0;
	int n0, t0, d0, a0, o0;

	aar_alert_reporter #(.RETX_CYCLES(RETX)) aar_alert_reporter_inst (.*);
	aar_master_model aar_master_model_inst (.*);

	initial begin
		forever #4 clock = ~clock;
	end

	// Pulse counters and cycle count
	always @(posedge clock) begin
		{ack_n, disc_n, ovf_n, cyc} <= {ack_n + int'(ack_r), disc_n + int'(reply_discard_r), ovf_n + int'(alert_overflow_r), cyc + 1};
	end

	task automatic step(input int k);
		repeat (k) @(negedge clock);
	endtask

	task automatic cfg(input logic p);
		@(negedge clock);
		{cfg_valid, cfg_port, cfg_tag, cfg_path} = {1'h1, p, tagv[p], pth[p]};
		@(negedge clock);
		cfg_valid = 0;
	endtask

	task automatic alert(input logic p, input logic x, input logic dn, input logic [7:0] ty, input int dl);
		@(negedge clock);
		{alert_port, alert_exit_port, alert_port_down, alert_type, alert_subtype, alert_info} = {p, x, dn, ty, ty + 8'h01, ty + 8'h02};
		{alert_valid, alert_ctrl, alert_chan, alert_dlen} = {1'h1, ~ty, ty, 8'h5a, 5'(dl)};
		@(negedge clock);
		alert_valid = 0;
	endtask

	task automatic wait_msg(input int lim);
		for (int k = 0; k < lim && msg_cnt == n0; k++) @(negedge clock);
		`CHK("message", 1'h1, msg_cnt != n0)
		n0 = msg_cnt;
	endtask

	task automatic chk_msg(input logic p, input logic dn, input logic [7:0] ty, input int dl);
		logic [87:0] e;
		e = {AAR_CODE_ALERT, 7'h0, p, tagv[p], dn ? {AAR_NOP_TYPE, AAR_NOP_SUB, AAR_NOP_INFO} : {ty, ty + 8'h01, ty + 8'h02}, 8'h00, ~ty, ty, 8'h5a};
		`CHK("length", 11 + dl, msg_len)
		for (int b = 0; b < 11 + dl; b++) `CHK("byte", b < 11 ? e[87 - 8*b -: 8] : 8'h80 + 8'(b - 11), msg[b])
		`CHK("path", {epth[p], p}, {tx_path_r, tx_path_len_r, tx_port_r})
	endtask

	task automatic treq(input logic sep, input logic [2:0] c, input logic ok, input logic [15:0] t);
		@(negedge clock);
		{pool_separate, tag_req_valid, tag_req_class} = {sep, 1'h1, c};
		@(negedge clock);
		tag_req_valid = 0;
		`CHK("tag", {ok, !ok, t}, {tag_grant_r, tag_fail_r, ok ? tag_grant_tag_r : t})
	endtask

	task automatic rel(input logic [2:0] c, input logic [15:0] t, input logic bad);
		@(negedge clock);
		{pool_separate, tag_rel_valid, tag_rel_class, tag_rel_tag} = {1'h1, 1'h1, c, t};
		@(negedge clock);
		tag_rel_valid = 0;
		`CHK("release", bad, tag_rel_bad_r)
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < AAR_MAX_DATA; i++) alert_data[8*i +: 8] = 8'h80 + 8'(i);
		step(20);
		rst = 0;
		step(1);
		`CHK("reset", 3'h0, {tx_valid, pending_r})
		cfg(0);
		cfg(1);
		n0 = msg_cnt;
		foreach (rows[r]) begin
			alert(rows[r].p, rows[r].x, rows[r].dn, rows[r].ty, rows[r].dl);
			`CHK("discard", !rows[r].sent, alert_discard_r)
			if (rows[r].sent) begin
				wait_msg(100);
				chk_msg(rows[r].p, rows[r].dn, rows[r].ty, rows[r].dl);
				step(8);
				`CHK("pending", 2'h0, {pending_r[rows[r].p], ack_invalid_r})
			end
		end
		// Unanswered alert resent, then wrong tag, then a doubled reply
		answer = 0;
		alert(0, 1, 0, 8'h02, 4);
		wait_msg(100);
		t0 = cyc;
		wait_msg(RETX + 100);
		`CHK("resend gap", 1'h1, (cyc - t0) inside {[RETX - 4:RETX + 8]})
		chk_msg(0, 0, 8'h02, 4);
		{answer, tag_xor, d0} = {1'h1, 16'h0001, disc_n};
		wait_msg(RETX + 100);
		step(8);
		`CHK("mismatch", {1'h1, d0 + 1}, {pending_r[0], disc_n})
		{tag_xor, twice, a0} = {16'h0000, 1'h1, ack_n};
		wait_msg(RETX + 100);
		step(12);
		`CHK("double reply", {a0 + 1, d0 + 2, 2'h1}, {ack_n, disc_n, pending_r[0], ack_invalid_r})
		twice = 0;
		// Tag pools: own, shared, exhausted, released, bad release
		treq(1, 3'h2, 1, 16'h0008);
		treq(1, 3'h5, 1, 16'h0014);
		treq(0, 3'h0, 1, 16'h0015);
		treq(0, 3'h3, 1, 16'h0016);
		treq(1, 3'h5, 1, 16'h0017);
		treq(0, 3'h1, 0, 16'h0000);
		rel(3'h5, 16'h0014, 0);
		rel(3'h2, 16'h0009, 1);
		treq(0, 3'h4, 1, 16'h0014);
		// Queue overflow on a crawling link, then node resets
		{stall, answer, o0} = {1'h1, 1'h0, ovf_n};
		repeat (5) alert(1, 0, 0, 8'h03, 0);
		step(2);
		`CHK("overflow", {o0 + 1, 1'h1}, {ovf_n, queue_full_r[1]})
		wait_msg(100);
		step(100);
		`CHK("one outstanding", {n0, 2'h2}, {msg_cnt, pending_r})
		total_reset = 1;
		step(1);
		total_reset = 0;
		step(4);
		`CHK("total reset", 4'h0, {pending_r, queue_full_r})
		stall = 0;
		cfg(0);
		alert(0, 1, 0, 8'h05, 0);
		wait_msg(100);
		absolute_reset = 1;
		step(1);
		absolute_reset = 0;
		step(RETX + 50);
		`CHK("absolute reset", {n0, 2'h0}, {msg_cnt, pending_r})
		complete_run;
	end

	// Watchdog against a hang
	initial begin
		#(10000 * 8);
		err_count++;
		$display("[FAIL] watchdog expired");
		complete_run;
	end
endmodule // aar_alert_reporter_test
